// ==== fan_cfg_pkg.sv ====
// Constants for the fan input and shared output pin configuration register
package fan_cfg_pkg;
  localparam logic [7:0] CFG_OFFSET      = 8'h05;
  localparam logic [7:0] CFG_RESET_VALUE = 8'h14;
  localparam int         RST_EN_BIT      = 7;
  localparam int         OT_EN_BIT       = 6;
  localparam int         TWO_DIV_MSB     = 5;
  localparam int         TWO_DIV_LSB     = 4;
  localparam int         ONE_DIV_MSB     = 3;
  localparam int         ONE_DIV_LSB     = 2;
  localparam int         TWO_MODE_BIT    = 1;
  localparam int         ONE_MODE_BIT    = 0;
  localparam int         DIV_MAX         = 8;
  localparam logic [7:0] RDATA_RESET     = 8'h00;
  localparam logic [3:0] PRESCALE_RESET  = 4'h2;
  localparam logic       FLAG_RESET      = 1'b0;
  localparam logic       PIN_OUT_LEVEL   = 1'b0;
  typedef enum logic [1:0] {
    PIN_OFF      = 2'b00,
    PIN_OVERTEMP = 2'b01,
    PIN_RESET    = 2'b11
  } pin_func_e;
endpackage

// ==== tach_and_output_pin_config.sv ====
// Fan input mode and shared reset/overtemperature pin configuration
// Overview of operation
// - A read/write configuration register lives at offset 0x05.
// - Bit 7 set makes the shared pin act as the reset output.
// - Bit 6 selects the overtemperature function only while bit 7 is 0.
// - With bits 7 and 6 both 0 the shared pin is disabled.
// - Bit 1 set puts fan input two in level mode, clear in pulse counting.
// - Bit 0 set puts fan input one in level mode, clear in pulse counting.
// - Level mode on input two with bit 4 set flags while the pin is low.
// - Level mode on input two with bit 4 clear flags while the pin is high.
// - Level mode on input one uses bit 2 the same way, clear is active high.
`timescale 1ns/10ps
`default_nettype none
module tach_and_output_pin_config (
  // Clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET_N,
  // Register port
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [7:0]            REG_WDATA,
  output var  logic [7:0]            REG_RDATA,
  // Pin sources
  input  wire logic                  RESET_REQUEST,
  input  wire logic                  OVERTEMP_EVENT,
  input  wire logic                  FAN_INPUT_ONE,
  input  wire logic                  FAN_INPUT_TWO,
  // Shared open-drain pin, active low
  output var  logic                  OVERTEMP_OUTPUT_PIN_OUT,
  output var  logic                  OVERTEMP_OUTPUT_PIN_OE,
  output var  fan_cfg_pkg::pin_func_e PIN_FUNCTION,
  // Fan channel configuration
  output var  logic                  FAN_ONE_INPUT_MODE,
  output var  logic                  FAN_TWO_INPUT_MODE,
  output var  logic [3:0]            FAN_ONE_PRESCALE,
  output var  logic [3:0]            FAN_TWO_PRESCALE,
  output var  logic                  FAN_ONE_LEVEL_EVENT,
  output var  logic                  FAN_TWO_LEVEL_EVENT
);
  import fan_cfg_pkg::*;

  // Configuration register and its next value
  logic [7:0]      cfg_reg;
  logic [7:0]      cfg_next;

  // Register port decode
  logic            addr_hit;
  logic            wr_hit;
  logic            rd_hit;
  logic [7:0]      rdata_next;

  // Shared pin function selection
  logic            rst_en;
  logic            ot_en;
  pin_func_e       func_next;
  logic            pin_assert;

  // Per channel view, index 0 is fan input one and index 1 fan input two
  logic [1:0]      chan_pin;
  logic [1:0]      chan_level;
  logic [1:0]      chan_act_low;
  logic [1:0]      chan_event;
  logic [1:0][1:0] chan_div;
  logic [1:0][3:0] chan_scale;

  // Register port decode
  assign addr_hit   = (REG_ADDR == CFG_OFFSET);
  assign wr_hit     = REG_WR && addr_hit;
  assign rd_hit     = REG_RD && addr_hit;
  // Unmapped reads return zero so the bus never sees stale data
  assign rdata_next = rd_hit ? cfg_reg : RDATA_RESET;

  // Shared pin enables
  assign rst_en     = cfg_reg[RST_EN_BIT];
  assign ot_en      = cfg_reg[OT_EN_BIT];

  // Reset wins over overtemperature when both enables are set
  assign func_next  = rst_en ? PIN_RESET :
                      ot_en  ? PIN_OVERTEMP :
                               PIN_OFF;

  // A disabled pin never asserts, whatever its sources do
  assign pin_assert = (func_next == PIN_RESET)    ? RESET_REQUEST :
                      (func_next == PIN_OVERTEMP) ? OVERTEMP_EVENT :
                                                    1'b0;

  // Fan pins gathered so both channels share one loop
  assign chan_pin   = {FAN_INPUT_TWO, FAN_INPUT_ONE};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      localparam int MODE_POS = (ch == 0) ? ONE_MODE_BIT : TWO_MODE_BIT;
      localparam int DIV_LSB  = (ch == 0) ? ONE_DIV_LSB : TWO_DIV_LSB;
      localparam int DIV_MSB  = (ch == 0) ? ONE_DIV_MSB : TWO_DIV_MSB;

      // Level mode when set, pulse counting when clear
      assign chan_level[ch]   = cfg_reg[MODE_POS];

      // Polarity bit shares the divisor field's low bit in level mode
      assign chan_act_low[ch] = cfg_reg[DIV_LSB];

      // Divisor field as a power of two
      assign chan_div[ch]     = cfg_reg[DIV_MSB:DIV_LSB];
      assign chan_scale[ch]   = 4'h1 << chan_div[ch];

      // Pulse counting mode never raises a level event
      assign chan_event[ch]   = chan_level[ch] &
                                (chan_pin[ch] ^ chan_act_low[ch]);
    end
  endgenerate

  // Write path: a write to any other offset is ignored
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_hit) begin
      cfg_next = REG_WDATA;
    end
  end

  // Configuration storage
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_reg <= CFG_RESET_VALUE;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Read data, registered so the bus sees a clean flop output
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= RDATA_RESET;
    end else begin
      REG_RDATA <= rdata_next;
    end
  end

  // Open drain pin: the driven level is always low
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OVERTEMP_OUTPUT_PIN_OUT <= PIN_OUT_LEVEL;
    end else begin
      OVERTEMP_OUTPUT_PIN_OUT <= PIN_OUT_LEVEL;
    end
  end

  // Drive low only while the selected function asserts
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OVERTEMP_OUTPUT_PIN_OE <= FLAG_RESET;
    end else begin
      OVERTEMP_OUTPUT_PIN_OE <= pin_assert;
    end
  end

  // Selected function of the shared pin
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PIN_FUNCTION <= PIN_OFF;
    end else begin
      PIN_FUNCTION <= func_next;
    end
  end

  // Fan input one mode
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAN_ONE_INPUT_MODE <= FLAG_RESET;
    end else begin
      FAN_ONE_INPUT_MODE <= chan_level[0];
    end
  end

  // Fan input two mode
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAN_TWO_INPUT_MODE <= FLAG_RESET;
    end else begin
      FAN_TWO_INPUT_MODE <= chan_level[1];
    end
  end

  // Fan input one prescale
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAN_ONE_PRESCALE <= PRESCALE_RESET;
    end else begin
      FAN_ONE_PRESCALE <= chan_scale[0];
    end
  end

  // Fan input two prescale
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAN_TWO_PRESCALE <= PRESCALE_RESET;
    end else begin
      FAN_TWO_PRESCALE <= chan_scale[1];
    end
  end

  // Level event of fan input one, one cycle behind the pin
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAN_ONE_LEVEL_EVENT <= FLAG_RESET;
    end else begin
      FAN_ONE_LEVEL_EVENT <= chan_event[0];
    end
  end

  // Level event of fan input two, one cycle behind the pin
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAN_TWO_LEVEL_EVENT <= FLAG_RESET;
    end else begin
      FAN_TWO_LEVEL_EVENT <= chan_event[1];
    end
  end

endmodule
`default_nettype wire

// ==== tach_cfg_monitor.sv ====
// Assertion checker for the fan and shared pin configuration block
`timescale 1ns/10ps
`default_nettype none
module tach_cfg_monitor import fan_cfg_pkg::*; (
  input wire logic       CORE_CLK, RESET_N, REG_WR, REG_RD,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  input wire logic       RESET_REQUEST, OVERTEMP_OUTPUT_PIN_OE,
  input wire logic       OVERTEMP_EVENT, FAN_INPUT_ONE, FAN_INPUT_TWO,
  input wire logic       FAN_ONE_LEVEL_EVENT, FAN_TWO_LEVEL_EVENT,
  input wire logic       FAN_ONE_INPUT_MODE, FAN_TWO_INPUT_MODE,
  input wire logic [3:0] FAN_TWO_PRESCALE,
  input wire pin_func_e  PIN_FUNCTION);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Outputs update one edge after the write is taken and are sampled at the second
  sequence wr_s(m); REG_WR && REG_ADDR == CFG_OFFSET && m; endsequence
  chk_mode_one: assert property (wr_s(1'b1) |-> ##2
    FAN_ONE_INPUT_MODE == $past(REG_WDATA[0], 2)) else $error("mode one");
  chk_mode_two: assert property (wr_s(1'b1) |-> ##2
    FAN_TWO_INPUT_MODE == $past(REG_WDATA[1], 2)) else $error("mode two");
  chk_reset_sel: assert property (wr_s(REG_WDATA[7]) |-> ##2
    PIN_FUNCTION == PIN_RESET) else $error("reset select");
  chk_ot_sel: assert property (wr_s(REG_WDATA[7:6] == 2'h1) |-> ##2
    PIN_FUNCTION == PIN_OVERTEMP) else $error("overtemp select");
  chk_pin_off: assert property (PIN_FUNCTION == PIN_OFF [*2]
    |-> !OVERTEMP_OUTPUT_PIN_OE) else $error("pin not off");
  chk_reset_drive: assert property (PIN_FUNCTION == PIN_RESET [*2]
    |-> OVERTEMP_OUTPUT_PIN_OE == $past(RESET_REQUEST)) else $error("oe");
  chk_ot_drive: assert property (PIN_FUNCTION == PIN_OVERTEMP [*2]
    |-> OVERTEMP_OUTPUT_PIN_OE == $past(OVERTEMP_EVENT)) else $error("ot");
  chk_two_low: assert property (wr_s(REG_WDATA[1] && REG_WDATA[4])
    |-> ##2 FAN_TWO_LEVEL_EVENT == !$past(FAN_INPUT_TWO))
    else $error("two low");
  chk_two_high: assert property (wr_s(REG_WDATA[1] && !REG_WDATA[4])
    |-> ##2 FAN_TWO_LEVEL_EVENT == $past(FAN_INPUT_TWO))
    else $error("two high");
  chk_one_level: assert property (wr_s(REG_WDATA[0]) |-> ##2
    FAN_ONE_LEVEL_EVENT == ($past(FAN_INPUT_ONE) ^ $past(REG_WDATA[2], 2)))
    else $error("one level");
  chk_bad_read: assert property (REG_RD && REG_ADDR != CFG_OFFSET
    |=> REG_RDATA == 8'h0) else $error("unmapped read");
  chk_two_scale: assert property (wr_s(1'b1) |-> ##2
    FAN_TWO_PRESCALE == 4'h1 << $past(REG_WDATA[5:4], 2)) else $error("div");
endmodule
bind tach_and_output_pin_config tach_cfg_monitor i_mon (.*);
`default_nettype wire

// ==== tach_and_output_pin_config_tb.sv ====
// Random self-checking bench for the fan and shared pin configuration
`timescale 1ns/10ps
`default_nettype none
module tach_and_output_pin_config_tb;
  import fan_cfg_pkg::*;
  logic CORE_CLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, RESET_REQUEST = 0;
  logic OVERTEMP_EVENT = 0, FAN_INPUT_ONE = 0, FAN_INPUT_TWO = 0;
  logic [7:0] REG_ADDR = 8'h0, REG_WDATA = 8'h0, REG_RDATA;
  logic OVERTEMP_OUTPUT_PIN_OUT, OVERTEMP_OUTPUT_PIN_OE, FAN_ONE_INPUT_MODE;
  logic FAN_TWO_INPUT_MODE, FAN_ONE_LEVEL_EVENT, FAN_TWO_LEVEL_EVENT;
  logic [3:0] FAN_ONE_PRESCALE, FAN_TWO_PRESCALE;
  pin_func_e PIN_FUNCTION;
  int bad_count = 0, checks_done = 0, cfg = CFG_RESET_VALUE, a, d;
  tach_and_output_pin_config i_tach_and_output_pin_config (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .RESET_REQUEST(RESET_REQUEST),
    .OVERTEMP_EVENT(OVERTEMP_EVENT), .FAN_INPUT_ONE(FAN_INPUT_ONE),
    .FAN_INPUT_TWO(FAN_INPUT_TWO),
    .OVERTEMP_OUTPUT_PIN_OUT(OVERTEMP_OUTPUT_PIN_OUT),
    .OVERTEMP_OUTPUT_PIN_OE(OVERTEMP_OUTPUT_PIN_OE),
    .PIN_FUNCTION(PIN_FUNCTION), .FAN_ONE_INPUT_MODE(FAN_ONE_INPUT_MODE),
    .FAN_TWO_INPUT_MODE(FAN_TWO_INPUT_MODE),
    .FAN_ONE_PRESCALE(FAN_ONE_PRESCALE), .FAN_TWO_PRESCALE(FAN_TWO_PRESCALE),
    .FAN_ONE_LEVEL_EVENT(FAN_ONE_LEVEL_EVENT),
    .FAN_TWO_LEVEL_EVENT(FAN_TWO_LEVEL_EVENT));
  initial forever #50 CORE_CLK = ~CORE_CLK;
  task automatic chk(string n, logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Each pass takes five cycles; the limit is about twice the whole run
  initial begin #200us; bad_count++; results; end
  initial begin
    void'($urandom(66));
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk("reset read data", RDATA_RESET, REG_RDATA);
    chk("reset outputs", {PIN_OUT_LEVEL, FLAG_RESET, PIN_OFF, 4'h0,
      PRESCALE_RESET, PRESCALE_RESET}, {OVERTEMP_OUTPUT_PIN_OUT,
      OVERTEMP_OUTPUT_PIN_OE, PIN_FUNCTION, FAN_TWO_INPUT_MODE,
      FAN_ONE_INPUT_MODE, FAN_TWO_LEVEL_EVENT, FAN_ONE_LEVEL_EVENT,
      FAN_TWO_PRESCALE, FAN_ONE_PRESCALE});
    $display("reset value test done");
    @(posedge CORE_CLK);
    RESET_N <= 1;
    for (int i = 0; i < 200; i++) begin
      @(posedge CORE_CLK);
      a = $urandom % 2 ? CFG_OFFSET : $urandom % 256;
      d = $urandom % 256;
      REG_WR <= $urandom % 4 != 0;
      REG_ADDR <= a[7:0];
      REG_WDATA <= d[7:0];
      {RESET_REQUEST, OVERTEMP_EVENT, FAN_INPUT_ONE, FAN_INPUT_TWO} <=
        4'($urandom);
      @(posedge CORE_CLK);
      if (REG_WR && a == CFG_OFFSET) cfg = d;
      REG_WR <= 0;
      REG_RD <= 1;
      @(posedge CORE_CLK);
      REG_RD <= 0;
      @(negedge CORE_CLK);
      chk("read data", a == CFG_OFFSET ? cfg : 0, REG_RDATA);
      repeat (2) @(negedge CORE_CLK);
      chk("outputs", {1'b0, cfg[7] ? RESET_REQUEST : cfg[6] & OVERTEMP_EVENT,
        cfg[7] ? 2'h3 : {1'b0, cfg[6]}, cfg[1], cfg[0],
        cfg[1] & (FAN_INPUT_TWO ^ cfg[4]), cfg[0] & (FAN_INPUT_ONE ^ cfg[2]),
        4'h1 << cfg[5:4], 4'h1 << cfg[3:2]}, {OVERTEMP_OUTPUT_PIN_OUT,
        OVERTEMP_OUTPUT_PIN_OE, PIN_FUNCTION, FAN_TWO_INPUT_MODE,
        FAN_ONE_INPUT_MODE, FAN_TWO_LEVEL_EVENT, FAN_ONE_LEVEL_EVENT,
        FAN_TWO_PRESCALE, FAN_ONE_PRESCALE});
    end
    $display("random register test done");
    results;
  end
endmodule
`default_nettype wire
